// File: hdl/rps_defines.svh
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

// =====================================================================
// clock rates
`define RPS_CLK_HZ        20000000
`define RPS_OSC_HZ        20000000

// =====================================================================
// times in oscillator cycles and derived clk_sys counts
`define RPS_T_WDRS_OSC    512
`define RPS_T_EXDLY_OSC   32
`define RPS_T_BOOTH_OSC   200
`define RPS_T_LOCK_OSC    131072
`define RPS_WDRS_CYC      ((`RPS_T_WDRS_OSC * (`RPS_CLK_HZ / 1000)) / (`RPS_OSC_HZ / 1000))
`define RPS_EXDLY_CYC     ((`RPS_T_EXDLY_OSC * (`RPS_CLK_HZ / 1000)) / (`RPS_OSC_HZ / 1000))
`define RPS_BOOTH_CYC     ((`RPS_T_BOOTH_OSC * (`RPS_CLK_HZ / 1000)) / (`RPS_OSC_HZ / 1000))
`define RPS_LOCK_CYC      ((`RPS_T_LOCK_OSC * (`RPS_CLK_HZ / 10000)) / (`RPS_OSC_HZ / 10000))

// =====================================================================
// widths, codes, reset values
`define RPS_CNT_W         18
`define RPS_RATIO_W       16
`define RPS_BOOT_W        4
`define RPS_RATIO_X2      16'h0004
`define RPS_RATIO_X4      16'h0008
`define RPS_RATIO_RST     16'h0000
`define RPS_MULT_X2       3'h2
`define RPS_MULT_X4       3'h4
`define RPS_MULT_X1       3'h1
`define RPS_BOOT_MEM_PAT  4'hF

`endif

// File: hdl/rps_pkg.sv
package rps_pkg;

   // =====================================================================
   // reset sequence states
   typedef enum logic [2:0] {
      RPS_ST_HELD = 3'b001,
      RPS_ST_WAIT = 3'b010,
      RPS_ST_RUN  = 3'b100
   } rps_state_type;

   // =====================================================================
   // system clock source
   typedef enum logic [3:0] {
      RPS_SRC_OSC  = 4'b0001,
      RPS_SRC_HALF = 4'b0010,
      RPS_SRC_PLL  = 4'b0100,
      RPS_SRC_LIMP = 4'b1000
   } rps_clksrc_type;

endpackage

// File: hdl/rps_counter.sv
`timescale 1ns/1ns
`include "rps_defines.svh"

module rps_counter #(
   parameter int W = `RPS_CNT_W
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic         clk_en,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   // status
   output logic              busy,
   output logic              done
);

   logic [W-1:0] cnt_r;
   logic         done_r;

   // =====================================================================
   // down counter, busy for exactly load_val cycles
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else if (clk_en) begin
         if (load) begin
            cnt_r <= load_val;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         done_r <= 1'b0;
      end else if (clk_en) begin
         done_r <= (cnt_r == W'(1)) && !load;
      end
   end

   assign busy = (cnt_r != '0);
   assign done = done_r;

endmodule

// File: hdl/rps_sequencer.sv
`timescale 1ns/1ns
`include "rps_defines.svh"

module rps_sequencer
   import rps_pkg::*;
#(
   parameter int LOCK_CYCLES = `RPS_LOCK_CYC
) (
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rstn,
   input  wire logic                       clk_en,
   // reset pin, open drain
   input  wire logic                       external_reset_pin_n_in,
   output logic                            external_reset_pin_n_out,
   output logic                            external_reset_pin_oe,
   // watchdog
   input  wire logic                       watchdog_trigger,
   // boot mode pins
   input  wire logic [`RPS_BOOT_W-1:0]     boot_mode_pins,
   // ratio control write
   input  wire logic                       pll_ratio_control_wr,
   input  wire logic [`RPS_RATIO_W-1:0]    pll_ratio_control_data,
   // clock configuration
   input  wire logic                       oscillator_missing,
   input  wire logic                       clock_output_enable,
   // sequence status
   output logic                            core_reset_n,
   output logic                            bus_active,
   output logic                            boot_valid,
   output logic [`RPS_BOOT_W-1:0]          boot_mode,
   output logic                            boot_to_memory,
   // clock status
   output rps_pkg::rps_clksrc_type         system_clock_source,
   output logic [2:0]                      system_clock_mult,
   output logic                            pll_locking,
   output logic                            clock_output_pin
);

   import rps_pkg::*;

   // =====================================================================
   // input synchronisers
   logic                   rst_s1_r, rst_s2_r;
   logic [`RPS_BOOT_W-1:0] boot_s1_r, boot_s2_r;
   logic                   limp_s1_r, limp_s2_r;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rst_s1_r  <= 1'b0;
         rst_s2_r  <= 1'b0;
         boot_s1_r <= '0;
         boot_s2_r <= '0;
         limp_s1_r <= 1'b0;
         limp_s2_r <= 1'b0;
      end else if (clk_en) begin
         rst_s1_r  <= external_reset_pin_n_in;
         rst_s2_r  <= rst_s1_r;
         boot_s1_r <= boot_mode_pins;
         boot_s2_r <= boot_s1_r;
         limp_s1_r <= oscillator_missing;
         limp_s2_r <= limp_s1_r;
      end
   end

   // =====================================================================
   // counters
   logic wd_load, wd_busy;
   logic ex_load, ex_done;
   logic lk_load, lk_busy, lk_done;
   // loads are one short: every output behind a counter is registered one cycle later

   rps_counter #(.W(`RPS_CNT_W)) u_wd_cnt (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .load     (wd_load),
      .load_val (`RPS_CNT_W'(`RPS_WDRS_CYC - 1)),
      .busy     (wd_busy),
      .done     ()
   );

   rps_counter #(.W(`RPS_CNT_W)) u_ex_cnt (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .load     (ex_load),
      .load_val (`RPS_CNT_W'(`RPS_EXDLY_CYC - 1)),
      .busy     (),
      .done     (ex_done)
   );

   rps_counter #(.W(`RPS_CNT_W)) u_lk_cnt (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .load     (lk_load),
      .load_val (`RPS_CNT_W'(LOCK_CYCLES - 1)),
      .busy     (lk_busy),
      .done     (lk_done)
   );

   // =====================================================================
   // reset sequence
   rps_state_type st_r, st_nxt;
   logic          pin_low;

   // pin low from board or from our own watchdog drive; the loop back keeps
   // the core held until the stretched pulse has really ended on the wire
   assign pin_low = !rst_s2_r || wd_busy;

   assign wd_load = watchdog_trigger && !wd_busy && (st_r == RPS_ST_RUN);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         RPS_ST_HELD: begin
            if (!pin_low) begin
               st_nxt = RPS_ST_WAIT;
            end
         end
         RPS_ST_WAIT: begin
            if (pin_low) begin
               st_nxt = RPS_ST_HELD;
            end else if (ex_done) begin
               st_nxt = RPS_ST_RUN;
            end
         end
         RPS_ST_RUN: begin
            if (pin_low || wd_load) begin
               st_nxt = RPS_ST_HELD;
            end
         end
         default: begin
            st_nxt = RPS_ST_HELD;
         end
      endcase
   end

   assign ex_load = (st_r == RPS_ST_HELD) && !pin_low;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_r <= RPS_ST_HELD;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         external_reset_pin_n_out <= 1'b0;
         external_reset_pin_oe    <= 1'b0;
         core_reset_n             <= 1'b0;
         bus_active               <= 1'b0;
      end else if (clk_en) begin
         external_reset_pin_n_out <= 1'b0;
         external_reset_pin_oe    <= wd_load || (wd_busy && !(st_r == RPS_ST_WAIT));
         core_reset_n             <= (st_nxt != RPS_ST_HELD);
         bus_active               <= (st_nxt == RPS_ST_RUN);
      end
   end

   // =====================================================================
   // boot mode capture
   // sampled at the end of the release delay, well inside the pin hold time
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         boot_valid     <= 1'b0;
         boot_mode      <= '0;
         boot_to_memory <= 1'b0;
      end else if (clk_en) begin
         if (st_nxt == RPS_ST_HELD) begin
            boot_valid <= 1'b0;
         end else if (st_r == RPS_ST_WAIT && ex_done) begin
            boot_valid     <= 1'b1;
            boot_mode      <= boot_s2_r;
            boot_to_memory <= (boot_s2_r == `RPS_BOOT_MEM_PAT);
         end
      end
   end

   // =====================================================================
   // ratio control and lock-up
   logic [`RPS_RATIO_W-1:0] ratio_r;
   logic [2:0]              mult_nxt;

   assign lk_load = pll_ratio_control_wr && core_reset_n;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ratio_r <= `RPS_RATIO_RST;
      end else if (clk_en) begin
         if (!core_reset_n) begin
            ratio_r <= `RPS_RATIO_RST;
         end else if (lk_load) begin
            ratio_r <= pll_ratio_control_data;
         end
      end
   end

   always_comb begin
      case (ratio_r)
         `RPS_RATIO_X2: mult_nxt = `RPS_MULT_X2;
         `RPS_RATIO_X4: mult_nxt = `RPS_MULT_X4;
         default:       mult_nxt = `RPS_MULT_X1;
      endcase
   end

   // =====================================================================
   // clock source select and output pin
   rps_clksrc_type src_want;
   logic           half_r;

   always_comb begin
      if (limp_s2_r) begin
         src_want = RPS_SRC_LIMP;
      end else if (lk_busy || lk_load) begin
         src_want = RPS_SRC_HALF;
      end else if (mult_nxt != `RPS_MULT_X1) begin
         src_want = RPS_SRC_PLL;
      end else begin
         src_want = RPS_SRC_OSC;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         half_r <= 1'b0;
      end else if (clk_en) begin
         half_r <= !half_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         system_clock_source <= RPS_SRC_OSC;
         system_clock_mult   <= `RPS_MULT_X1;
         pll_locking         <= 1'b0;
      end else if (clk_en) begin
         pll_locking <= lk_busy || lk_load;
         if (half_r) begin
            system_clock_source <= src_want;
            if (lk_done || !(lk_busy || lk_load)) begin
               system_clock_mult <= mult_nxt;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clock_output_pin <= 1'b0;
      end else if (clk_en) begin
         clock_output_pin <= clock_output_enable && !half_r;
      end
   end

endmodule

// File: sim/rps_board_model.sv
`timescale 1ns/1ns

module rps_board_model #(
   parameter int MIN_LOW = 8,
   parameter int PWR_LOW = 20000
) (
   // board controls
   input  wire logic       clk_sys,
   input  wire logic       board_hold,
   input  wire logic [3:0] boot_sel,
   // device side
   input  wire logic       device_oe,
   output logic            pin_n,
   output logic [3:0]      boot_pins
);
   int         low_cnt = 0;
   int         hi_cnt  = 0;
   int         lim     = PWR_LOW;
   logic       pull_r  = 1'b1;
   logic [3:0] boot_r  = 4'h0;
   // =====================================================================
   // reset pin: pull-up unless someone pulls low
   assign pin_n = !(pull_r || device_oe);
   always @(posedge clk_sys) begin
      if (board_hold) begin
         low_cnt <= 0;
         pull_r  <= 1'b1;
      end else if (pull_r) begin
         low_cnt <= low_cnt + 1;
         if (low_cnt + 1 >= lim) begin
            pull_r <= 1'b0;
            lim    <= MIN_LOW;
         end
      end
   end
   // pins held, then no longer valid
   always @(posedge clk_sys) begin
      if (!pin_n) begin
         boot_r <= boot_sel;
         hi_cnt <= 0;
      end else if (hi_cnt < 1000) begin
         hi_cnt <= hi_cnt + 1;
      end
   end
   assign boot_pins = (hi_cnt < 200) ? boot_r : ~boot_r;
endmodule

// File: sim/rps_chk.sv
`timescale 1ns/1ns
`include "rps_defines.svh"

module rps_chk
   import rps_pkg::*;
#(
   parameter int LOCK_CYCLES = 64
) (
   // clock and reset
   input wire logic                    clk_sys,
   input wire logic                    rstn,
   // inputs
   input wire logic                    watchdog_trigger,
   input wire logic                    pll_ratio_control_wr,
   input wire logic [15:0]             pll_ratio_control_data,
   input wire logic                    oscillator_missing,
   input wire logic                    clock_output_enable,
   // outputs
   input wire logic                    external_reset_pin_oe,
   input wire logic                    core_reset_n,
   input wire logic                    bus_active,
   input wire logic                    boot_valid,
   input wire logic [3:0]              boot_mode,
   input wire logic                    boot_to_memory,
   input rps_pkg::rps_clksrc_type      system_clock_source,
   input wire logic [2:0]              system_clock_mult,
   input wire logic                    pll_locking,
   input wire logic                    clock_output_pin
);
   int       oe_cnt_r;
   int       lk_cnt_r;
   logic [2:0] mult_r;
   // =====================================================================
   // helper counters
   always_ff @(posedge clk_sys) begin
      oe_cnt_r <= (!rstn || !external_reset_pin_oe) ? 0 : oe_cnt_r + 1;
   end
   // a fresh write restarts the lock count
   always_ff @(posedge clk_sys) begin
      if (!rstn || pll_ratio_control_wr) lk_cnt_r <= 0;
      else if (pll_locking) lk_cnt_r <= lk_cnt_r + 1;
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) mult_r <= `RPS_MULT_X1;
      else if (pll_ratio_control_wr && core_reset_n)
         mult_r <= (pll_ratio_control_data == `RPS_RATIO_X2) ? `RPS_MULT_X2 :
                   (pll_ratio_control_data == `RPS_RATIO_X4) ? `RPS_MULT_X4 : `RPS_MULT_X1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_wd; watchdog_trigger && bus_active && !external_reset_pin_oe
      |=> external_reset_pin_oe && !core_reset_n && !bus_active; endproperty
   a_wd: assert property (p_wd)
      else $error("watchdog pulse not started");
   property p_wdlen; $fell(external_reset_pin_oe) |-> oe_cnt_r == 512; endproperty
   a_wdlen: assert property (p_wdlen)
      else $error("watchdog pulse length wrong");
   property p_bus; $rose(core_reset_n) |-> !bus_active ##32 bus_active; endproperty
   a_bus: assert property (p_bus)
      else $error("bus activity delay wrong");
   property p_boot; boot_valid |-> boot_to_memory == (boot_mode == `RPS_BOOT_MEM_PAT);
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot branch wrong");
   property p_lock; pll_ratio_control_wr && core_reset_n |=> pll_locking; endproperty
   a_lock: assert property (p_lock)
      else $error("lock-up not entered");
   property p_half; $rose(pll_locking) && !oscillator_missing
      |-> ##[0:3] system_clock_source == RPS_SRC_HALF; endproperty
   a_half: assert property (p_half)
      else $error("half clock not selected");
   property p_lklen; $fell(pll_locking) |-> lk_cnt_r == LOCK_CYCLES; endproperty
   a_lklen: assert property (p_lklen)
      else $error("lock-up length wrong");
   property p_mult; $fell(pll_locking) && !oscillator_missing |-> ##[0:3]
      system_clock_mult == mult_r; endproperty
   a_mult: assert property (p_mult)
      else $error("multiplier wrong");
   property p_limp; oscillator_missing[*6] |-> system_clock_source == RPS_SRC_LIMP;
   endproperty
   a_limp: assert property (p_limp)
      else $error("limp source not selected");
   property p_ckout; clock_output_enable[*2] |=> clock_output_pin != $past(clock_output_pin);
   endproperty
   a_ckout: assert property (p_ckout)
      else $error("clock output not toggling");
   // a source change must land where the output pin shows the low half
   property p_glitch; $changed(system_clock_source) && $past(clock_output_enable)
      |-> !clock_output_pin; endproperty
   a_glitch: assert property (p_glitch)
      else $error("clock source switched mid phase");
endmodule

bind rps_sequencer rps_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.*);

// File: sim/tb_top.sv
`timescale 1ns/1ns
`include "rps_defines.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t: got %0h exp %0h", $time, a, b); end end

module tb_top;
   import rps_pkg::*;
   localparam int LOCK = 64;
   logic           clk_sys = 1'b0, rstn = 1'b0, clk_en = 1'b1, hold = 1'b0;
   logic           wdog = 1'b0, wr = 1'b0, osc_miss = 1'b0, ck_en = 1'b0;
   logic [15:0]    wdata = 16'h0000;
   logic [3:0]     bsel = 4'hF, boot_pins, bmode;
   logic           pin_n, pin_out, oe, core_n, bus, b_mem, locking, ck_pin, v;
   logic [2:0]     mult;
   rps_clksrc_type src;
   int             fails = 0, comparisons = 0;
   // =====================================================================
   // design and board
   rps_sequencer #(.LOCK_CYCLES(LOCK)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
      .clk_en(clk_en), .external_reset_pin_n_in(pin_n), .external_reset_pin_n_out(pin_out),
      .external_reset_pin_oe(oe), .watchdog_trigger(wdog), .boot_mode_pins(boot_pins),
      .pll_ratio_control_wr(wr), .pll_ratio_control_data(wdata),
      .oscillator_missing(osc_miss), .clock_output_enable(ck_en), .core_reset_n(core_n),
      .bus_active(bus), .boot_valid(), .boot_mode(bmode), .boot_to_memory(b_mem),
      .system_clock_source(src), .system_clock_mult(mult), .pll_locking(locking),
      .clock_output_pin(ck_pin));
   rps_board_model board_u (.clk_sys(clk_sys), .board_hold(hold), .boot_sel(bsel),
      .device_oe(oe), .pin_n(pin_n), .boot_pins(boot_pins));
   always #25 clk_sys = ~clk_sys;
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic finish_test();
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tmo();
      fails++;
      $display("ERROR %0t: wait timed out", $time);
      finish_test();
   endtask
   // shared by every reset source
   task automatic t_release(input logic [3:0] pat);
      int n;
      for (n = 0; n < 30000 && core_n !== 1'b1; n++) step();
      if (core_n !== 1'b1) tmo();
      for (n = 0; n < 100 && bus !== 1'b1; n++) step();
      `CHK(n, 32)
      `CHK(bmode, pat)
      `CHK(b_mem, pat == `RPS_BOOT_MEM_PAT)
   endtask
   task automatic t_pin(input logic [3:0] pat);
      int n;
      bsel = pat;
      hold = 1'b1;
      step();
      hold = 1'b0;
      for (n = 0; n < 20 && core_n !== 1'b0; n++) step();
      if (core_n !== 1'b0) tmo();
      t_release(pat);
   endtask
   task automatic t_pll(input logic [15:0] d, input logic [2:0] m, input rps_clksrc_type s);
      int n;
      wdata = d;
      wr = 1'b1;
      step();
      wr = 1'b0;
      `CHK(locking, 1'b1)
      for (n = 0; n < 3 && src !== RPS_SRC_HALF; n++) step();
      `CHK(src, RPS_SRC_HALF)
      for (n = 0; n < 200 && locking === 1'b1; n++) step();
      `CHK(n > LOCK - 4, 1'b1)
      step();
      step();
      `CHK(mult, m)
      `CHK(src, s)
   endtask
   // ratio writes just after the pulse, with the core still held, must be refused
   task automatic t_wdog();
      int n;
      wdog = 1'b1;
      step();
      wdog = 1'b0;
      `CHK(oe, 1'b1)
      `CHK(pin_out, 1'b0)
      for (n = 0; n < 600 && oe === 1'b1; n++) step();
      `CHK(n, 512)
      wr = 1'b1;
      step();
      wr = 1'b0;
      step();
      `CHK(locking, 1'b0)
      t_release(bsel);
   endtask
   initial begin
      repeat (2) step();
      rstn = 1'b1;
      `CHK(src, RPS_SRC_OSC)
      t_release(4'hF);
      t_pin(4'h5);
      t_pll(`RPS_RATIO_X4, `RPS_MULT_X4, RPS_SRC_PLL);
      t_pll(16'h0003, `RPS_MULT_X1, RPS_SRC_OSC);
      wdata = `RPS_RATIO_X4;
      wr = 1'b1;
      step();
      wr = 1'b0;
      repeat (30) step();
      t_pll(`RPS_RATIO_X2, `RPS_MULT_X2, RPS_SRC_PLL);
      t_wdog();
      osc_miss = 1'b1;
      repeat (6) step();
      `CHK(src, RPS_SRC_LIMP)
      osc_miss = 1'b0;
      ck_en = 1'b1;
      repeat (3) step();
      v = ck_pin;
      step();
      `CHK(ck_pin, ~v)
      ck_en = 1'b0;
      repeat (2) step();
      `CHK(ck_pin, 1'b0)
      finish_test();
   end
endmodule
